// *** inc/trace_trigger_pkg.sv ***
// Constants, types and register map of the trace trigger unit.
// Assumes one 50 MHz clock shared by the APB bus and the emulated core.
package trace_trigger_pkg;

    // -------------------------------------------------------------------------
    // Code memory and tag geometry.
    // -------------------------------------------------------------------------
    localparam int ADDR_W    = 13;
    localparam int MEM_DEPTH = 8192;

    // -------------------------------------------------------------------------
    // Address limits for the three emulated variants.
    // -------------------------------------------------------------------------
    localparam logic [1:0]        VARIANT_SMALL  = 2'h0;
    localparam logic [1:0]        VARIANT_MID    = 2'h1;
    localparam logic [1:0]        VARIANT_LARGE  = 2'h2;
    localparam logic [ADDR_W-1:0] LIMIT_SMALL    = 13'h07df;
    localparam logic [ADDR_W-1:0] LIMIT_MID      = 13'h0fdf;
    localparam logic [ADDR_W-1:0] LIMIT_LARGE    = 13'h1fdf;

    // -------------------------------------------------------------------------
    // Register byte offsets on the APB bus.
    // -------------------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND    = 8'h00;
    localparam logic [7:0] OFS_START_ADDR = 8'h04;
    localparam logic [7:0] OFS_STOP_ADDR  = 8'h08;
    localparam logic [7:0] OFS_VARIANT    = 8'h0c;
    localparam logic [7:0] OFS_TAG_ADDR   = 8'h10;
    localparam logic [7:0] OFS_TAG_DATA   = 8'h14;
    localparam logic [7:0] OFS_STATUS     = 8'h18;

    // -------------------------------------------------------------------------
    // Field positions.
    // -------------------------------------------------------------------------
    localparam int CMD_SET_BIT     = 0;
    localparam int CMD_CLEAR_BIT   = 1;
    localparam int TAG_ENABLE_BIT  = 0;
    localparam int TAG_START_BIT   = 1;
    localparam int TAG_STOP_BIT    = 2;
    localparam int STAT_TRIG_BIT   = 0;
    localparam int STAT_ACTIVE_BIT = 1;
    localparam int STAT_ERROR_BIT  = 2;
    localparam int STAT_BUSY_BIT   = 3;

    // -------------------------------------------------------------------------
    // Reset values.
    // -------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RESET_TRIG_ADDR = 13'h0000;
    localparam logic [1:0]        RESET_VARIANT   = VARIANT_SMALL;

    // -------------------------------------------------------------------------
    // Types.
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {WIPE, IDLE, CLR_OLD, SET_NEW} tag_state_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } fetch_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } capture_t;

endpackage

// *** hw/trace_trigger_unit.sv ***
// Trace qualification for the emulator: decides which executed instructions
// enter the trace, from per-address enable, start and stop tags.
// Assumes an APB master and the emulated core on SYS_CLK, one fetch report
// per executed instruction, at the address of its first byte.
//
// Notes on behaviour
// - One enable, one start and one stop tag bit are kept for every code address.
// - In address tracing an instruction is captured when its enable tag is 1.
// - Enable tags qualify capture only in address tracing, never in trigger tracing.
// - In trigger tracing capture begins at an address whose start tag is 1.
// - In trigger tracing capture ends at an address whose stop tag is 1.
// - The start-tagged instruction is captured and the stop-tagged one is not.
// - The clear command selects address tracing and the set command selects trigger tracing.
// - Reset selects address tracing.
// - A run that begins at the start address starts capture only on the second pass there.
// - The set command places the start tag at the start address and the stop tag at the stop address.
// - Trigger settings stay in force after a set command until a clear command or the next accepted set command.
// - Trigger addresses are accepted only within the range of the selected variant.
`timescale 1ns/100ps

module trace_trigger_unit
    import trace_trigger_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire fetch_t      FETCH,
    input  wire logic        RUN_START,
    output capture_t         CAPTURE
);

    // -------------------------------------------------------------------------
    // Helpers.
    // -------------------------------------------------------------------------
    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [1:0]        v);
        logic [ADDR_W-1:0] lim;
        lim = LIMIT_LARGE;
        if (v == VARIANT_SMALL)
        begin
            lim = LIMIT_SMALL;
        end
        else if (v == VARIANT_MID)
        begin
            lim = LIMIT_MID;
        end
        return a <= lim;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFS_COMMAND || a == OFS_START_ADDR || a == OFS_STOP_ADDR
            || a == OFS_VARIANT || a == OFS_TAG_ADDR || a == OFS_TAG_DATA
            || a == OFS_STATUS;
    endfunction

    // -------------------------------------------------------------------------
    // Tag memories.
    // -------------------------------------------------------------------------
    logic enable_mem [0:MEM_DEPTH-1];
    logic start_mem  [0:MEM_DEPTH-1];
    logic stop_mem   [0:MEM_DEPTH-1];

    logic              en_we;
    logic [ADDR_W-1:0] en_wa;
    logic              en_wd;
    logic              st_we;
    logic [ADDR_W-1:0] st_wa;
    logic              st_wd;
    logic              sp_we;
    logic [ADDR_W-1:0] sp_wa;
    logic              sp_wd;

    // -------------------------------------------------------------------------
    // State.
    // -------------------------------------------------------------------------
    tag_state_t        state;
    tag_state_t        next_state;
    logic [ADDR_W-1:0] wipe_ptr;
    logic [ADDR_W-1:0] next_wipe_ptr;
    logic              trig_mode;
    logic              next_trig_mode;
    logic              active;
    logic              next_active;
    logic              first_fetch;
    logic              next_first_fetch;
    logic              pending_set;
    logic              next_pending_set;
    logic              cmd_error;
    logic              next_cmd_error;
    logic [ADDR_W-1:0] start_addr;
    logic [ADDR_W-1:0] next_start_addr;
    logic [ADDR_W-1:0] stop_addr;
    logic [ADDR_W-1:0] next_stop_addr;
    logic [ADDR_W-1:0] new_start;
    logic [ADDR_W-1:0] next_new_start;
    logic [ADDR_W-1:0] new_stop;
    logic [ADDR_W-1:0] next_new_stop;
    logic [1:0]        variant;
    logic [1:0]        next_variant;
    logic [ADDR_W-1:0] tag_addr;
    logic [ADDR_W-1:0] next_tag_addr;
    logic [31:0]       prdata;
    logic [31:0]       next_prdata;
    capture_t          capture;
    capture_t          next_capture;

    logic              wr;
    logic              hit_start;
    logic              hit_stop;
    logic              hit_enable;

    // -------------------------------------------------------------------------
    // Bus answers.
    // -------------------------------------------------------------------------
    // Accesses wait while the tag memories are being wiped or rewritten.
    assign PREADY  = (state == IDLE);
    assign PSLVERR = PSEL && PENABLE && PREADY && !is_mapped(PADDR);
    assign PRDATA  = prdata;
    assign CAPTURE = capture;
    assign wr      = PSEL && PENABLE && PWRITE && PREADY && is_mapped(PADDR);

    assign hit_enable = enable_mem[FETCH.addr];
    assign hit_start  = start_mem[FETCH.addr] && !first_fetch;
    assign hit_stop   = stop_mem[FETCH.addr];

    // -------------------------------------------------------------------------
    // Next-state logic.
    // -------------------------------------------------------------------------
    always_comb
    begin
        next_state       = state;
        next_wipe_ptr    = wipe_ptr;
        next_trig_mode   = trig_mode;
        next_active      = active;
        next_first_fetch = first_fetch;
        next_pending_set = pending_set;
        next_cmd_error   = cmd_error;
        next_start_addr  = start_addr;
        next_stop_addr   = stop_addr;
        next_new_start   = new_start;
        next_new_stop    = new_stop;
        next_variant     = variant;
        next_tag_addr    = tag_addr;
        next_prdata      = prdata;
        next_capture     = '{valid: 1'b0, addr: FETCH.addr};
        en_we = 1'b0;
        en_wa = tag_addr;
        en_wd = PWDATA[TAG_ENABLE_BIT];
        st_we = 1'b0;
        st_wa = start_addr;
        st_wd = 1'b0;
        sp_we = 1'b0;
        sp_wa = stop_addr;
        sp_wd = 1'b0;

        // Tag sequencer.
        unique case (state)
            WIPE:
            begin
                en_we = 1'b1;
                en_wa = wipe_ptr;
                en_wd = 1'b0;
                st_we = 1'b1;
                st_wa = wipe_ptr;
                sp_we = 1'b1;
                sp_wa = wipe_ptr;
                next_wipe_ptr = wipe_ptr + 13'h0001;
                if (wipe_ptr == 13'h1fff)
                begin
                    next_state = IDLE;
                end
            end
            IDLE:
            begin
                if (wr && PADDR == OFS_TAG_DATA)
                begin
                    en_we = 1'b1;
                end
            end
            CLR_OLD:
            begin
                // Old trigger tags are removed before new ones are placed.
                st_we = 1'b1;
                sp_we = 1'b1;
                next_state = pending_set ? SET_NEW : IDLE;
            end
            SET_NEW:
            begin
                st_we = 1'b1;
                st_wa = new_start;
                st_wd = 1'b1;
                sp_we = 1'b1;
                sp_wa = new_stop;
                sp_wd = 1'b1;
                next_start_addr = new_start;
                next_stop_addr  = new_stop;
                next_state      = IDLE;
            end
        endcase

        // Register writes.
        if (wr)
        begin
            unique case (PADDR)
                OFS_COMMAND:
                begin
                    if (PWDATA[CMD_CLEAR_BIT])
                    begin
                        next_trig_mode   = 1'b0;
                        next_active      = 1'b0;
                        next_pending_set = 1'b0;
                        next_cmd_error   = 1'b0;
                        next_state       = CLR_OLD;
                    end
                    else if (PWDATA[CMD_SET_BIT])
                    begin
                        if (in_range(new_start, variant) && in_range(new_stop, variant))
                        begin
                            next_trig_mode   = 1'b1;
                            next_active      = 1'b0;
                            next_pending_set = 1'b1;
                            next_cmd_error   = 1'b0;
                            next_state       = CLR_OLD;
                        end
                        else
                        begin
                            next_cmd_error = 1'b1;
                        end
                    end
                end
                OFS_START_ADDR: next_new_start = PWDATA[ADDR_W-1:0];
                OFS_STOP_ADDR:  next_new_stop  = PWDATA[ADDR_W-1:0];
                OFS_VARIANT:    next_variant   = PWDATA[1:0];
                OFS_TAG_ADDR:   next_tag_addr  = PWDATA[ADDR_W-1:0];
                default:        next_prdata    = prdata;
            endcase
        end

        // Read data is refreshed while the access waits.
        if (PSEL && !PWRITE && !(PENABLE && PREADY))
        begin
            next_prdata = 32'h0000_0000;
            unique case (PADDR)
                OFS_START_ADDR: next_prdata[ADDR_W-1:0] = new_start;
                OFS_STOP_ADDR:  next_prdata[ADDR_W-1:0] = new_stop;
                OFS_VARIANT:    next_prdata[1:0]        = variant;
                OFS_TAG_ADDR:   next_prdata[ADDR_W-1:0] = tag_addr;
                OFS_TAG_DATA:
                begin
                    next_prdata[TAG_ENABLE_BIT] = enable_mem[tag_addr];
                    next_prdata[TAG_START_BIT]  = start_mem[tag_addr];
                    next_prdata[TAG_STOP_BIT]   = stop_mem[tag_addr];
                end
                OFS_STATUS:
                begin
                    next_prdata[STAT_TRIG_BIT]   = trig_mode;
                    next_prdata[STAT_ACTIVE_BIT] = active;
                    next_prdata[STAT_ERROR_BIT]  = cmd_error;
                    next_prdata[STAT_BUSY_BIT]   = (next_state != IDLE);
                end
                default:        next_prdata = 32'h0000_0000;
            endcase
        end

        // Capture qualification, once per reported fetch.
        if (FETCH.valid)
        begin
            next_first_fetch = 1'b0;
            if (!trig_mode)
            begin
                next_capture.valid = hit_enable;
            end
            else if (hit_stop)
            begin
                next_capture.valid = 1'b0;
                next_active        = 1'b0;
            end
            else if (hit_start || active)
            begin
                next_capture.valid = 1'b1;
                next_active        = 1'b1;
            end
        end

        // A new run marks its first fetch so a start tag there is skipped.
        if (RUN_START)
        begin
            next_first_fetch = 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // State registers.
    // -------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state       <= WIPE;
            wipe_ptr    <= 13'h0000;
            trig_mode   <= 1'b0;
            active      <= 1'b0;
            first_fetch <= 1'b0;
            pending_set <= 1'b0;
            cmd_error   <= 1'b0;
            start_addr  <= RESET_TRIG_ADDR;
            stop_addr   <= RESET_TRIG_ADDR;
            new_start   <= RESET_TRIG_ADDR;
            new_stop    <= RESET_TRIG_ADDR;
            variant     <= RESET_VARIANT;
            tag_addr    <= 13'h0000;
            prdata      <= 32'h0000_0000;
            capture     <= '0;
        end
        else
        begin
            state       <= next_state;
            wipe_ptr    <= next_wipe_ptr;
            trig_mode   <= next_trig_mode;
            active      <= next_active;
            first_fetch <= next_first_fetch;
            pending_set <= next_pending_set;
            cmd_error   <= next_cmd_error;
            start_addr  <= next_start_addr;
            stop_addr   <= next_stop_addr;
            new_start   <= next_new_start;
            new_stop    <= next_new_stop;
            variant     <= next_variant;
            tag_addr    <= next_tag_addr;
            prdata      <= next_prdata;
            capture     <= next_capture;
        end
    end

    // -------------------------------------------------------------------------
    // Tag memory writes.
    // -------------------------------------------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (en_we)
        begin
            enable_mem[en_wa] <= en_wd;
        end
        if (st_we)
        begin
            start_mem[st_wa] <= st_wd;
        end
        if (sp_we)
        begin
            stop_mem[sp_wa] <= sp_wd;
        end
    end

endmodule

// *** test/trace_trigger_unit_props.sv ***
// Checker for the trace trigger unit, bound to its top module.
// Assumes the APB master and the core drive inputs just after SYS_CLK rises.
`timescale 1ns/100ps
module trace_trigger_unit_props
    import trace_trigger_pkg::*;
(
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire fetch_t      FETCH,
    input wire logic        RUN_START,
    input wire capture_t    CAPTURE
);
    logic [13:0] wipe_cnt;
    logic [13:0] next_wipe_cnt;
    logic        rd_done, wr_done;
    logic [ADDR_W-1:0] st_seen, sp_seen, lim_seen;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // Counts edges since reset release, saturating at the wipe length.
    always_comb
    begin
        next_wipe_cnt = wipe_cnt;
        if (wipe_cnt != 14'h2000)
            next_wipe_cnt = wipe_cnt + 14'h0001;
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            wipe_cnt <= 14'h0000;
        else
            wipe_cnt <= next_wipe_cnt;
    end
    assign rd_done = PSEL && PENABLE && PREADY && !PWRITE;
    assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            {st_seen, sp_seen, lim_seen} <= {26'h0, LIMIT_SMALL};
        else if (wr_done && PADDR == OFS_START_ADDR)
            st_seen <= PWDATA[ADDR_W-1:0];
        else if (wr_done && PADDR == OFS_STOP_ADDR)
            sp_seen <= PWDATA[ADDR_W-1:0];
        else if (wr_done && PADDR == OFS_VARIANT)
            lim_seen <= PWDATA[1] ? LIMIT_LARGE : PWDATA[0] ? LIMIT_MID : LIMIT_SMALL;
    end
    sequence cmd_taken;
        PSEL && PENABLE && PREADY && PWRITE && PADDR == OFS_COMMAND
            && PWDATA[1:0] != 2'h0
            && (PWDATA[1] || st_seen <= lim_seen && sp_seen <= lim_seen);
    endsequence
    sequence tag_update;
        !PREADY ##[1:2] PREADY;
    endsequence
    chk_wipe_ready: assert property (PREADY |-> wipe_cnt == 14'h2000)
        else $error("bus answered before the tag wipe ended");
    chk_cmd_sequence: assert property (cmd_taken |=> tag_update)
        else $error("command did not place tags in two cycles");
    chk_capture_cause: assert property (CAPTURE.valid |-> $past(FETCH.valid))
        else $error("capture without a fetch");
    chk_capture_addr: assert property (CAPTURE.valid |-> CAPTURE.addr == $past(FETCH.addr))
        else $error("capture address differs from fetch");
    chk_err_phase: assert property (PSLVERR |-> PSEL && PENABLE && PREADY)
        else $error("slave error outside the access phase");
    chk_err_rdata: assert property (rd_done && PSLVERR |-> PRDATA == 32'h0)
        else $error("unmapped read returned data");
    chk_cmd_reads_zero: assert property (rd_done && PADDR == OFS_COMMAND |-> PRDATA == 32'h0)
        else $error("command register read not zero");
    chk_tag_width: assert property (rd_done && PADDR == OFS_TAG_DATA |-> PRDATA[31:3] == 29'h0)
        else $error("tag read has stray bits");
endmodule
bind trace_trigger_unit trace_trigger_unit_props props_u (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FETCH(FETCH),
    .RUN_START(RUN_START), .CAPTURE(CAPTURE));

// *** test/core_model.sv ***
// Emulated core: runs a looping program and reports each executed instruction.
// Assumes go is a one-cycle pulse given while busy is low.
`timescale 1ns/100ps
module core_model
    import trace_trigger_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              go,
    input  wire logic              slow,
    input  wire logic [ADDR_W-1:0] base,
    input  wire logic [7:0]        len,
    input  wire logic [7:0]        count,
    output fetch_t                 fetch,
    output logic                   run_start,
    output logic                   busy
);
    int i;
    int wait_n;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fetch <= '0;
            run_start <= 1'b0;
            busy <= 1'b0;
            i <= 0;
            wait_n <= 0;
        end
        else
        begin
            run_start <= go && !busy;
            // Idle cycles show a changing address, never the last one.
            fetch <= {1'b0, ~fetch.addr};
            if (go && !busy)
            begin
                busy <= 1'b1;
                i <= 0;
                wait_n <= 0;
            end
            else if (busy && wait_n > 0)
                wait_n <= wait_n - 1;
            else if (busy && i == int'(count))
                busy <= 1'b0;
            else if (busy)
            begin
                fetch <= {1'b1, ADDR_W'(int'(base) + i % int'(len))};
                i <= i + 1;
                wait_n <= slow ? 1 : 0;
            end
        end
    end
endmodule

// *** test/trace_trigger_unit_bench.sv ***
// Self-checking bench for the trace trigger unit with a reference model.
// Assumes the core model of core_model.sv and the bound checker.
`timescale 1ns/100ps
module trace_trigger_unit_bench;
    import trace_trigger_pkg::*;
    logic              clk = 1'b0, rst = 1'b1, go = 1'b0, slow = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00, len = 8'h01, count = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata, rd;
    logic [ADDR_W-1:0] base = '0;
    logic              pready, pslverr, run_start, busy, er;
    fetch_t            fetch;
    capture_t          capture;
    bit                en [MEM_DEPTH];
    int trig = 0, act = 0, first = 0, efl = 0, sa = -1, sp = -1, ss = 0, sq = 0;
    int variant = 0, tag_a = 0, pv = 0, ev = 0, ea = 0, b = 0, seed = 22579;
    int err_total = 0, n_compared = 0;
    trace_trigger_unit dut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .FETCH(fetch), .RUN_START(run_start), .CAPTURE(capture));
    core_model core (.clk(clk), .rst(rst), .go(go), .slow(slow), .base(base), .len(len),
        .count(count), .fetch(fetch), .run_start(run_start), .busy(busy));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    function automatic int lim(input int v);
        return v == 0 ? int'(LIMIT_SMALL) : v == 1 ? int'(LIMIT_MID) : int'(LIMIT_LARGE);
    endfunction
    function automatic int tagx();
        return (sp == tag_a) * 4 + (sa == tag_a) * 2 + int'(en[tag_a]);
    endfunction
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 10000)
        begin
            n++;
            @(posedge clk);
        end
        check(32'(n < 10000), 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && er === 1'b0)
            case (a)
                OFS_START_ADDR: ss = d[12:0];
                OFS_STOP_ADDR: sq = d[12:0];
                OFS_VARIANT: variant = d[1:0];
                OFS_TAG_ADDR: tag_a = d[12:0];
                OFS_TAG_DATA: en[tag_a] = d[0];
                OFS_COMMAND:
                    if (d[CMD_CLEAR_BIT])
                    begin
                        trig = 0;
                        efl = 0;
                        act = 0;
                        sa = -1;
                        sp = -1;
                    end
                    else if (d[CMD_SET_BIT] && ss <= lim(variant) && sq <= lim(variant))
                    begin
                        trig = 1;
                        act = 0;
                        sa = ss;
                        sp = sq;
                        efl = 0;
                    end
                    else if (d[CMD_SET_BIT])
                        efl = 1;
                default: ;
            endcase
    endtask
    task rdchk(input logic [7:0] a, input int exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask
    task run(input int bs, input logic [7:0] l, input logic [7:0] c);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        base <= ADDR_W'(bs);
        len <= l;
        count <= c;
        slow <= 1'($random(seed));
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1 && n < 2000)
        begin
            n++;
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask
    task tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Reference capture decision, evaluated at every fetch edge.
    always @(posedge clk)
    begin
        if (pv != 0)
        begin
            check(32'(capture.valid), ev);
            if (ev != 0)
                check(32'(capture.addr), ea);
        end
        pv = !rst && fetch.valid === 1'b1;
        if (pv != 0)
        begin
            ea = fetch.addr;
            if (trig == 0)
                ev = en[fetch.addr];
            else if (ea == sp)
            begin
                ev = 0;
                act = 0;
            end
            else
            begin
                if (ea == sa && first == 0)
                    act = 1;
                ev = act;
            end
            first = 0;
        end
        if (run_start === 1'b1)
            first = 1;
    end
    initial
    begin
        #(20 * 40000);
        err_total++;
        tally_and_finish;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFS_STATUS, 0);
        rdchk(OFS_VARIANT, 0);
        rdchk(OFS_TAG_DATA, 0);
        $display("test reset values done");
        apb(1'b1, 8'h1c, 32'h5);
        check(32'(er), 1);
        apb(1'b0, 8'h1c, 32'h0);
        check(32'(er), 1);
        check(rd, 0);
        rdchk(OFS_COMMAND, 0);
        $display("test unmapped access done");
        b = $unsigned($random(seed)) % 1900;
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, OFS_TAG_ADDR, b + i);
            apb(1'b1, OFS_TAG_DATA, $random(seed) & 1);
            rdchk(OFS_TAG_DATA, tagx());
        end
        run(b, 16, 16);
        $display("test address tracing done");
        apb(1'b1, OFS_START_ADDR, b + 4);
        apb(1'b1, OFS_STOP_ADDR, b + 12);
        rdchk(OFS_START_ADDR, b + 4);
        apb(1'b1, OFS_COMMAND, 32'h1);
        rdchk(OFS_STATUS, efl * 4 + trig);
        for (int i = 4; i <= 12; i += 8)
        begin
            apb(1'b1, OFS_TAG_ADDR, b + i);
            rdchk(OFS_TAG_DATA, tagx());
        end
        run(b, 16, 16);
        run(b + 4, 4, 12);
        rdchk(OFS_STATUS, efl * 4 + act * 2 + trig);
        $display("test trigger tracing done");
        for (int v = 0; v < 4; v++)
        begin
            apb(1'b1, OFS_VARIANT, v);
            rdchk(OFS_VARIANT, v);
            apb(1'b1, OFS_START_ADDR, lim(v));
            apb(1'b1, OFS_STOP_ADDR, lim(v) + 1);
            apb(1'b1, OFS_COMMAND, 32'h1);
            rdchk(OFS_STATUS, efl * 4 + act * 2 + trig);
            apb(1'b1, OFS_STOP_ADDR, lim(v));
            apb(1'b1, OFS_COMMAND, 32'h1);
            rdchk(OFS_STATUS, efl * 4 + act * 2 + trig);
        end
        $display("test variant ranges done");
        apb(1'b1, OFS_COMMAND, 32'h3);
        rdchk(OFS_STATUS, efl * 4 + trig);
        apb(1'b1, OFS_TAG_ADDR, lim(3));
        rdchk(OFS_TAG_DATA, tagx());
        run(b, 16, 16);
        $display("test clear command done");
        tally_and_finish;
    end
endmodule
